// >>> spwc_pkg.sv
// Constants for the power and wake-up controller.
// Assumes a 100 MHz system clock and byte-wide special function registers.
package spwc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Internal power-on pulse width and clock settle time, least times
  localparam int unsigned POR_PULSE_NS = 1000;
  localparam int unsigned CLK_SETTLE_NS = 200;
  localparam int unsigned POR_CYCLES =
    (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYCLES =
    (CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  // Register offsets
  localparam logic [7:0] PWR_CTRL_OFS = 8'h94;
  localparam logic [7:0] WAKE_STAT_OFS = 8'hEA;

  // Control register fields
  localparam int unsigned KEEP_BIT = 7;
  localparam int unsigned CLKSEL_BIT = 6;
  localparam int unsigned LF_RECEIVER_ENABLE_BIT = 5;

  // Status register fields
  localparam int unsigned ST_POR_BIT = 7;
  localparam int unsigned ST_LF_BIT = 5;
  localparam int unsigned ST_TMR1_BIT = 4;
  localparam int unsigned ST_HWRST_BIT = 3;
  localparam int unsigned ST_VALID_BIT = 2;
  localparam int unsigned ST_TMR2_BIT = 1;
  localparam int unsigned ST_XTAL_BIT = 0;

  // Status after power-on (flag bits only, crystal bit is live)
  localparam logic [7:0] STAT_POR_RST = 8'h3E;
  // Status reloaded at each power-off
  localparam logic [7:0] STAT_OFF_RST = 8'hBE;

  // Synchronised input lanes
  localparam int unsigned NSYNC = 6;
  localparam int unsigned SI_VREG = 0;
  localparam int unsigned SI_TMR = 1;
  localparam int unsigned SI_LF = 2;
  localparam int unsigned SI_ABS = 3;
  localparam int unsigned SI_XTAL = 4;
  localparam int unsigned SI_HWRST_N = 5;

  typedef enum logic [2:0] {
    ST_POR, ST_REG_START, ST_CLK_START, ST_RUN, ST_SLEEP
  } spwc_state_t;
endpackage

// >>> spwc_sync.sv
// Two-flop synchronisers, one lane per bit.
// Assumes each lane is a slow level from outside the clock domain.
`timescale 1ns/1ps
module spwc_sync #(
  parameter int unsigned N = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Lanes
  input wire logic [N-1:0] d,
  output logic [N-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_lane
      logic meta_ff;
      logic out_ff;
      always_ff @(posedge clk) begin
        if (srst) begin
          meta_ff <= 1'b0;
          out_ff <= 1'b0;
        end else begin
          meta_ff <= d[i];
          out_ff <= meta_ff;
        end
      end
      assign q[i] = out_ff;
    end
  endgenerate
endmodule

// >>> spwc_wake_status.sv
// Wake-cause capture register.
// Assumes timer_rise and lf_wake are single-cycle pulses on the system clock.
`timescale 1ns/1ps
module spwc_wake_status
  import spwc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Session state
  input wire logic powering_off,
  input wire logic mcu_on,
  // Events
  input wire logic timer_rise,
  input wire logic timer_level,
  input wire logic lf_wake,
  input wire logic hw_reset_seen,
  input wire logic xtal_active,
  // Status
  output logic [7:0] status
);
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;

  always_comb begin
    nxt_flags = flags_ff;
    if (powering_off) begin
      nxt_flags = STAT_OFF_RST; // Flags live for one session only
    end else if (mcu_on) begin
      if (timer_rise) begin
        if (flags_ff[ST_TMR1_BIT]) begin
          nxt_flags[ST_TMR1_BIT] = 1'b0; // [RULE_12]
        end else begin
          nxt_flags[ST_VALID_BIT] = 1'b0; // [RULE_14]
          nxt_flags[ST_TMR2_BIT] = 1'b0;
        end
      end
    end else begin
      if (timer_rise) begin
        nxt_flags[ST_TMR1_BIT] = 1'b0; // [RULE_11]
        nxt_flags[ST_TMR2_BIT] = 1'b0;
      end
      if (lf_wake) begin
        nxt_flags[ST_LF_BIT] = 1'b0; // [RULE_11]
        // LF after the timer pulse fell gives back the first timer flag
        if (!timer_level && !timer_rise && !flags_ff[ST_TMR2_BIT]) begin
          nxt_flags[ST_TMR1_BIT] = 1'b1; // [RULE_13]
        end
      end
    end
    if (hw_reset_seen && !powering_off) begin
      nxt_flags[ST_HWRST_BIT] = 1'b0; // [RULE_09]
    end
  end

  // Captured flags change only on events; never on bus writes [RULE_22]
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_ff <= STAT_POR_RST; // [RULE_09]
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_comb begin
    status = flags_ff;
    status[ST_XTAL_BIT] = xtal_active; // [RULE_10]
  end
endmodule

// >>> spwc_system_power_wakeup_control.sv
// Power and wake-up sequencer with its two special function registers.
// Assumes srst models battery attach and the core strobes one SFR access
// per cycle; external status levels arrive asynchronously.
// Behaviour
// RULE_01: Internal power-on pulse precedes everything.
// RULE_02: Regulator first, clock on ready, then MCU.
// RULE_03: Wake only on POR, LF, or timer.
// RULE_04: LF wakes only after confirmed pattern match.
// RULE_05: Writing keep bit zero powers off next edge.
// RULE_06: Keep bit returns to one; events wake.
// RULE_07: Clock select one picks crystal, zero RC.
// RULE_08: LF receiver enable is single-shot, aborts without signal.
// RULE_09: Power-on and hardware-reset flags active low.
// RULE_10: Crystal flag reads one while crystal active.
// RULE_11: LF and timer wakes give defined codes.
// RULE_12: Timer during LF session clears bit four.
// RULE_13: LF near timer edges gives codes D, E.
// RULE_14: Second timer while on clears invalid flag.
// RULE_15: Firmware treats undefined codes as errors.
// RULE_16: Firmware handles LF before timer work.
// RULE_17: Periodic operation wakes from interval timer.
// RULE_18: Motion mode: timer wake, measure, maybe sleep.
// RULE_19: Only software requests sleep.
// RULE_20: Firmware starts crystal before selecting it.
// RULE_21: Status register is read-only.
// RULE_22: Wake flags hold until next power-off.
`timescale 1ns/1ps
module spwc_system_power_wakeup_control
  import spwc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Analog and wake sources, asynchronous
  input wire logic regulator_ready,
  input wire logic timer_wake,
  input wire logic wake_by_lowfreq_trigger,
  input wire logic lf_signal_absent,
  input wire logic xtal_active,
  input wire logic hw_reset_n,
  // Sequencing outputs
  output logic por_pulse,
  output logic regulator_enable,
  output logic clock_enable,
  output logic mcu_run,
  output logic main_power_on,
  // Control outputs
  output logic main_clock_source_sel,
  output logic lf_receiver_enable
);
  import spwc_pkg::*;

  logic [NSYNC-1:0] sync_q;
  logic vreg_s, tmr_s, lf_s, abs_s, xtal_s, hwrst_n_s;
  logic tmr_prev_ff, lf_prev_ff, abs_prev_ff;
  logic timer_rise, lf_match, lf_absent;
  logic [7:0] status;

  spwc_sync #(.N(NSYNC)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({hw_reset_n, xtal_active, lf_signal_absent,
        wake_by_lowfreq_trigger, timer_wake, regulator_ready}),
    .q(sync_q)
  );

  assign vreg_s = sync_q[SI_VREG];
  assign tmr_s = sync_q[SI_TMR];
  assign lf_s = sync_q[SI_LF];
  assign abs_s = sync_q[SI_ABS];
  assign xtal_s = sync_q[SI_XTAL];
  assign hwrst_n_s = sync_q[SI_HWRST_N];

  // Edge detection on synchronised levels
  always_ff @(posedge clk) begin
    if (srst) begin
      tmr_prev_ff <= 1'b0;
      lf_prev_ff <= 1'b0;
      abs_prev_ff <= 1'b0;
    end else begin
      tmr_prev_ff <= tmr_s;
      lf_prev_ff <= lf_s;
      abs_prev_ff <= abs_s;
    end
  end

  assign timer_rise = tmr_s && !tmr_prev_ff;
  // The LF detector only raises this after its pattern compare passes
  assign lf_match = lf_s && !lf_prev_ff; // [RULE_04]
  assign lf_absent = abs_s && !abs_prev_ff;

  // Sequencer
  spwc_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic keep_wr0;

  assign keep_wr0 = sfr_wr && (sfr_addr == PWR_CTRL_OFS) &&
                    !sfr_wdata[KEEP_BIT];

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      ST_POR: begin
        // Hold the internal reset for its full width [RULE_01]
        if (cnt_ff == CNT_W'(POR_CYCLES - 1)) begin
          nxt_state = ST_REG_START;
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_REG_START: begin
        if (vreg_s) begin
          nxt_state = ST_CLK_START; // [RULE_02]
          nxt_cnt = '0;
        end
      end
      ST_CLK_START: begin
        if (cnt_ff == CNT_W'(SETTLE_CYCLES - 1)) begin
          nxt_state = ST_RUN; // [RULE_02]
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_RUN: begin
        // Sleep is entered only on the software request [RULE_19]
        if (keep_wr0) begin
          nxt_state = ST_SLEEP; // [RULE_05]
        end
      end
      ST_SLEEP: begin
        if (timer_rise || lf_match) begin
          nxt_state = ST_REG_START; // [RULE_03] [RULE_17]
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_POR;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Sequencing outputs registered from the next state
  logic por_ff, reg_en_ff, clk_en_ff, run_ff, pwr_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      por_ff <= 1'b1;
      reg_en_ff <= 1'b0;
      clk_en_ff <= 1'b0;
      run_ff <= 1'b0;
      pwr_ff <= 1'b1;
    end else begin
      por_ff <= (nxt_state == ST_POR); // [RULE_01]
      reg_en_ff <= (nxt_state != ST_POR) && (nxt_state != ST_SLEEP);
      clk_en_ff <= (nxt_state == ST_CLK_START) || (nxt_state == ST_RUN);
      run_ff <= (nxt_state == ST_RUN); // [RULE_02]
      pwr_ff <= (nxt_state != ST_SLEEP); // [RULE_05]
    end
  end

  assign por_pulse = por_ff;
  assign regulator_enable = reg_en_ff;
  assign clock_enable = clk_en_ff;
  assign mcu_run = run_ff;
  assign main_power_on = pwr_ff;

  // Control register; the keep bit is zero only until sleep reloads it
  logic keep_ff, nxt_keep;
  logic clksel_ff, nxt_clksel;
  logic lf_receiver_enable_ff, nxt_lf_receiver_enable;
  logic powering_off;

  assign powering_off = (state_ff == ST_RUN) && keep_wr0;

  always_comb begin
    nxt_keep = keep_ff;
    nxt_clksel = clksel_ff;
    nxt_lf_receiver_enable = lf_receiver_enable_ff;
    if (state_ff == ST_SLEEP) begin
      nxt_keep = 1'b1; // [RULE_06]
      nxt_lf_receiver_enable = 1'b0;
    end else if (sfr_wr && (sfr_addr == PWR_CTRL_OFS)) begin
      nxt_keep = sfr_wdata[KEEP_BIT];
      nxt_clksel = sfr_wdata[CLKSEL_BIT]; // [RULE_07]
      nxt_lf_receiver_enable = sfr_wdata[LF_RECEIVER_ENABLE_BIT]; // [RULE_08]
    end else if (lf_receiver_enable_ff && (lf_match || lf_absent)) begin
      // One attempt only: ends on a hit or on silence
      nxt_lf_receiver_enable = 1'b0; // [RULE_08]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      keep_ff <= 1'b1;
      clksel_ff <= 1'b0;
      lf_receiver_enable_ff <= 1'b0;
    end else begin
      keep_ff <= nxt_keep;
      clksel_ff <= nxt_clksel;
      lf_receiver_enable_ff <= nxt_lf_receiver_enable;
    end
  end

  assign main_clock_source_sel = clksel_ff; // [RULE_07]
  assign lf_receiver_enable = lf_receiver_enable_ff;

  // Wake-cause status
  spwc_wake_status u_status (
    .clk(clk),
    .srst(srst),
    .powering_off(powering_off),
    .mcu_on(state_ff == ST_RUN),
    .timer_rise(timer_rise),
    .timer_level(tmr_s),
    // LF during start-up still counts, so near-coincident codes form
    .lf_wake((state_ff != ST_RUN) && lf_match), // [RULE_13]
    .hw_reset_seen(!hwrst_n_s && (state_ff == ST_RUN)),
    .xtal_active(xtal_s),
    .status(status)
  );

  // Read path; write-only and unmapped addresses read zero
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    // Writes to the status address reach nothing [RULE_21]
    if (sfr_rd && (sfr_addr == WAKE_STAT_OFS)) begin
      nxt_rdata = status;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_POR_FIRST: assert property ( // [RULE_01]
    $fell(por_ff) |-> !clk_en_ff && !run_ff)
    else $error("clock or MCU started during power-on pulse");

  AST_CLK_AFTER_VREG: assert property ( // [RULE_02]
    $rose(clk_en_ff) |-> $past(vreg_s) && reg_en_ff)
    else $error("clock enabled before regulator ready");

  AST_RUN_AFTER_CLK: assert property ( // [RULE_02]
    $rose(run_ff) |-> $past(clk_en_ff, 8))
    else $error("MCU released before clock settled");

  AST_PWR_OFF_NEXT: assert property ( // [RULE_05]
    (state_ff == ST_RUN) && keep_wr0 |=> !pwr_ff && !run_ff)
    else $error("power-off request not honoured next edge");

  AST_KEEP_RETURNS: assert property ( // [RULE_06]
    !pwr_ff |=> keep_ff)
    else $error("keep bit not restored after power-off");

  AST_WAKE_SOURCES: assert property ( // [RULE_03]
    (state_ff == ST_SLEEP) && !timer_rise && !lf_match
      |=> state_ff == ST_SLEEP)
    else $error("left sleep without a wake source");

  AST_ONLY_SW_SLEEP: assert property ( // [RULE_19]
    $fell(pwr_ff) |-> $past(keep_wr0))
    else $error("power dropped without software request");

  AST_CLKSEL_OUT: assert property ( // [RULE_07]
    sfr_wr && (sfr_addr == PWR_CTRL_OFS) && (state_ff != ST_SLEEP)
      |=> main_clock_source_sel == $past(sfr_wdata[CLKSEL_BIT]))
    else $error("clock select did not follow write");

  AST_LF_RECEIVER_ENABLE_SHOT: assert property ( // [RULE_08]
    lf_receiver_enable_ff && lf_absent && !sfr_wr |=> !lf_receiver_enable_ff)
    else $error("LF receiver stayed on after no signal");

  AST_XTAL_FLAG: assert property ( // [RULE_10]
    sfr_rd && (sfr_addr == WAKE_STAT_OFS)
      |=> rdata_ff[ST_XTAL_BIT] == $past(xtal_s))
    else $error("crystal flag mismatch");

  AST_STATUS_STABLE: assert property ( // [RULE_22]
    (state_ff == ST_RUN) && !timer_rise && !powering_off && hwrst_n_s
      |=> $stable(status[7:1]))
    else $error("wake flags changed without event");
endmodule

// >>> spwc_fw_model.sv
// Far-side model: regulator and crystal levels seen by the controller.
// Assumes the bench plays firmware and drives the crystal start request.
`timescale 1ns/1ps
module spwc_fw_model #(
  parameter int unsigned READY_DLY = 8
) (
  // Clock
  input wire logic clk,
  // Requests
  input wire logic regulator_enable,
  input wire logic xtal_start,
  // Status levels
  output logic regulator_ready,
  output logic xtal_active
);
  logic [7:0] reg_cnt_ff;
  logic [7:0] nxt_reg_cnt;
  logic [2:0] xtal_sr_ff;
  logic [2:0] nxt_xtal_sr;

  always_comb begin
    // Ready falls on the next clock edge after the supply is cut, never lingers
    nxt_reg_cnt = 8'h00;
    if (regulator_enable) begin
      nxt_reg_cnt = reg_cnt_ff + 8'((reg_cnt_ff < READY_DLY));
    end
    // Crystal needs a few cycles to stand by before it may be chosen
    nxt_xtal_sr = {xtal_sr_ff[1:0], xtal_start};
  end

  always_ff @(posedge clk) begin
    reg_cnt_ff <= nxt_reg_cnt;
    xtal_sr_ff <= nxt_xtal_sr;
  end

  assign regulator_ready = (reg_cnt_ff >= READY_DLY);
  assign xtal_active = xtal_sr_ff[2];
endmodule

// >>> tb.sv
// Self-checking bench for the power and wake-up controller.
// Assumes the far-side model supplies regulator and crystal levels.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  import spwc_pkg::*;
  logic clk, srst, sfr_wr, sfr_rd, xtal_start;
  logic timer_wake, wake_by_lowfreq_trigger, lf_signal_absent, hw_reset_n;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, q;
  logic regulator_ready, xtal_active, por_pulse, regulator_enable;
  logic clock_enable, mcu_run, main_power_on;
  logic main_clock_source_sel, lf_receiver_enable;
  int fails, check_count, cyc;

  spwc_system_power_wakeup_control i_spwc_system_power_wakeup_control (
    .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .regulator_ready(regulator_ready), .timer_wake(timer_wake),
    .wake_by_lowfreq_trigger(wake_by_lowfreq_trigger),
    .lf_signal_absent(lf_signal_absent), .xtal_active(xtal_active),
    .hw_reset_n(hw_reset_n), .por_pulse(por_pulse),
    .regulator_enable(regulator_enable), .clock_enable(clock_enable),
    .mcu_run(mcu_run), .main_power_on(main_power_on),
    .main_clock_source_sel(main_clock_source_sel),
    .lf_receiver_enable(lf_receiver_enable));

  spwc_fw_model i_spwc_fw_model (
    .clk(clk), .regulator_enable(regulator_enable),
    .xtal_start(xtal_start), .regulator_ready(regulator_ready),
    .xtal_active(xtal_active));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    q = sfr_rdata;
  endtask

  task stat(input logic [7:0] ex);
    logic legal;
    rd(WAKE_STAT_OFS);
    `CHK("status", ex, q)
    // Firmware view: a wake code outside the defined set is an error
    legal = !q[ST_POR_BIT] ||
            ({q[ST_LF_BIT], q[ST_TMR1_BIT], q[ST_VALID_BIT],
              q[ST_TMR2_BIT]} inside
             {4'h7, 4'h3, 4'hA, 4'h6, 4'h2, 4'h8, 4'h0});
    `CHK("code_legal", 1'b1, legal)
  endtask

  task wait_run;
    int n;
    logic ordered;
    n = 0;
    while (mcu_run !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
      ordered = (clock_enable !== 1'b1) || (regulator_ready === 1'b1);
      `CHK("clk_order", 1'b1, ordered)
    end
    `CHK("mcu_run", 1'b1, mcu_run)
    `CHK("clk_on", 1'b1, clock_enable)
    `CHK("power_back", 1'b1, main_power_on)
  endtask

  // Firmware alone decides when to sleep
  task sleep_now;
    wr(PWR_CTRL_OFS, 8'h00);
    `CHK("power_off", 1'b0, main_power_on)
    `CHK("mcu_off", 1'b0, mcu_run)
    timer_wake = 1'b0;
    wake_by_lowfreq_trigger = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task t_por;
    repeat (16) @(negedge clk);
    `CHK("por_in_rst", 1'b1, por_pulse)
    srst = 1'b0;
    repeat (50) @(negedge clk);
    `CHK("por_held", 1'b1, por_pulse)
    `CHK("reg_waits", 1'b0, regulator_enable)
    wait_run();
    stat(8'h3E);
    $display("test por done");
  endtask

  task t_ctrl;
    rd(PWR_CTRL_OFS);
    `CHK("ctrl_rd", 8'h00, q)
    rd(8'h55);
    `CHK("unmapped_rd", 8'h00, q)
    xtal_start = 1'b1;
    repeat (6) @(negedge clk);
    wr(PWR_CTRL_OFS, 8'hC0);
    `CHK("clk_sel_x", 1'b1, main_clock_source_sel)
    stat(8'h3F);
    wr(WAKE_STAT_OFS, 8'h00);
    stat(8'h3F);
    wr(PWR_CTRL_OFS, 8'h80);
    `CHK("clk_sel_rc", 1'b0, main_clock_source_sel)
    xtal_start = 1'b0;
    repeat (6) @(negedge clk);
    stat(8'h3E);
    wr(PWR_CTRL_OFS, 8'hA0);
    `CHK("lf_on", 1'b1, lf_receiver_enable)
    lf_signal_absent = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("lf_abort", 1'b0, lf_receiver_enable)
    lf_signal_absent = 1'b0;
    hw_reset_n = 1'b0;
    repeat (5) @(negedge clk);
    hw_reset_n = 1'b1;
    repeat (20) @(negedge clk);
    stat(8'h36);
    sleep_now();
    repeat (60) @(negedge clk);
    `CHK("stay_asleep", 1'b0, main_power_on)
    $display("test control done");
  endtask

  task t_timer;
    timer_wake = 1'b1;
    wait_run();
    stat(8'hAC);
    repeat (30) @(negedge clk);
    stat(8'hAC);
    timer_wake = 1'b0;
    repeat (5) @(negedge clk);
    timer_wake = 1'b1;
    repeat (5) @(negedge clk);
    stat(8'hA8);
    // Motion reading below threshold: straight back to sleep
    sleep_now();
    $display("test timer done");
  endtask

  task t_lf;
    wake_by_lowfreq_trigger = 1'b1;
    wait_run();
    stat(8'h9E);
    timer_wake = 1'b1;
    repeat (5) @(negedge clk);
    stat(8'h8E);
    // LF work done first; the cleared first timer flag says timer work is due
    `CHK("timer_work_due", 1'b0, q[ST_TMR1_BIT])
    `CHK("lf_session", 1'b1, mcu_run)
    timer_wake = 1'b0;
    repeat (5) @(negedge clk);
    timer_wake = 1'b1;
    repeat (5) @(negedge clk);
    stat(8'h88);
    sleep_now();
    $display("test lf done");
  endtask

  task t_near;
    timer_wake = 1'b1;
    repeat (4) @(negedge clk);
    wake_by_lowfreq_trigger = 1'b1;
    wait_run();
    stat(8'h8C);
    sleep_now();
    timer_wake = 1'b1;
    repeat (3) @(negedge clk);
    timer_wake = 1'b0;
    repeat (4) @(negedge clk);
    wake_by_lowfreq_trigger = 1'b1;
    wait_run();
    stat(8'h9C);
    sleep_now();
    $display("test near done");
  endtask

  initial begin
    srst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    xtal_start = 1'b0;
    timer_wake = 1'b0;
    wake_by_lowfreq_trigger = 1'b0;
    lf_signal_absent = 1'b0;
    hw_reset_n = 1'b1;
    fails = 0;
    check_count = 0;
    cyc = 0;
    t_por();
    t_ctrl();
    t_timer();
    t_lf();
    t_near();
    tally_and_finish();
  end
endmodule
